//--- logic/ssrd_link_if.sv
// Serial link between the port and its peer: clock, and one data line each way.
// The clock wire is resolved from both drivers' enables; a non-driven wire idles high.
`timescale 1ns/1ns
interface ssrd_link_if;
  logic sclkPortOut;
  logic sclkPortOe;
  logic sclkPeerOut;
  logic sclkPeerOe;
  logic sclk;
  logic portToPeer;
  logic peerToPort;
  assign sclk = sclkPortOe ? sclkPortOut : (sclkPeerOe ? sclkPeerOut : 1'b1);
  modport port (
    output sclkPortOut,
    output sclkPortOe,
    input sclk,
    output portToPeer,
    input peerToPort
  );
  modport peer (
    output sclkPeerOut,
    output sclkPeerOe,
    input sclk,
    input portToPeer,
    output peerToPort
  );
endinterface : ssrd_link_if

//--- logic/ssrd_peer.sv
// Serial peer: makes the link clock by a divider, shifts a reply byte out and a byte in.
// Assumes the port is set to external clock, edge bit 0, MSB first.
`timescale 1ns/1ns
module ssrd_peer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [7:0] replyByte,
  output logic busy,
  output logic [7:0] rxByte,
  output logic rxValid,
  ssrd_link_if.peer link
);
  logic [7:0] half_r;
  logic [3:0] edgeCnt_r;
  logic sclk_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic active_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      half_r <= 8'h0;
      edgeCnt_r <= 4'h0;
      sclk_r <= 1'b1;
      tx_r <= ssrd_pkg::PEER_REPLY_RST;
      rx_r <= 8'h0;
      active_r <= 1'b0;
      rxByte <= 8'h0;
      rxValid <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      if (!active_r) begin
        if (go) begin
          active_r <= 1'b1;
          tx_r <= replyByte;
          half_r <= 8'h0;
          edgeCnt_r <= 4'h0;
        end
      end else if (half_r == 8'(ssrd_pkg::PEER_HALF_CYC - 1)) begin
        half_r <= 8'h0;
        sclk_r <= ~sclk_r;
        if (sclk_r) begin
          // Falling edge: launch next bit
          if (edgeCnt_r != 4'h0) begin
            tx_r <= {tx_r[6:0], 1'b1};
          end
        end else begin
          // Port data is same-clock logic; a synchroniser would lag it by a bit
          rx_r <= {rx_r[6:0], link.portToPeer};
          edgeCnt_r <= edgeCnt_r + 4'h1;
          if (edgeCnt_r == 4'h7) begin
            active_r <= 1'b0;
            rxByte <= {rx_r[6:0], link.portToPeer};
            rxValid <= 1'b1;
          end
        end
      end else begin
        half_r <= half_r + 8'h1;
      end
    end
  end

  assign busy = active_r;
  assign link.sclkPeerOut = sclk_r;
  assign link.sclkPeerOe = 1'b1;
  assign link.peerToPort = tx_r[7];
endmodule : ssrd_peer

//--- logic/ssrd_pkg.sv
// Shared constants for the synchronous serial receive/duplex port and its peer.
// Assumes both ends are clocked at 20 MHz; the serial clock is sampled, never used as a clock.
package ssrd_pkg;
  localparam int CLK_HZ = 20000000;
  // Register offsets of the port, one aligned 32-bit word each
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS = 4'h8;
  // Control register fields
  localparam int MODE_LSB = 0;
  localparam int START_BIT = 2;
  localparam int EDGE_BIT = 3;
  localparam int ORDER_BIT = 4;
  localparam int CKS_LSB = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Status register fields
  localparam int ST_INPROG = 0;
  localparam int ST_SHIFT = 1;
  localparam int ST_RCOMP = 2;
  localparam int ST_OVR = 3;
  localparam int ST_UND = 4;
  localparam int ST_TBFULL = 5;
  localparam logic [5:0] STAT_RST = 6'h00;
  // Mode and clock-select codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RX = 2'h2;
  localparam logic [1:0] MODE_DUPLEX = 2'h3;
  localparam logic [2:0] CKS_EXT = 3'h7;
  // Internal serial clock half period per clock-select code: 2^(cks+1) cycles
  localparam int HALF_BASE_LOG2 = 1;
  localparam logic [7:0] TXDATA_RST = 8'hff;
  // Peer reply register reset value, driven until the first request loads replyByte; arbitrary default
  localparam logic [7:0] PEER_REPLY_RST = 8'h00;
  // Peer serial clock half period at 400 ns period
  localparam int PEER_PERIOD_NS = 400;
  localparam int PEER_HALF_CYC = (PEER_PERIOD_NS / 2) * (CLK_HZ / 1000000) / 1000;
endpackage : ssrd_pkg

//--- logic/ssrd_port.sv
// Synchronous serial port: 8-bit receive and full-duplex modes, APB register slave.
// Assumes the peer drives the serial clock only when clock-select is external.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns
module ssrd_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic portInterrupt,
  ssrd_link_if.port link
);
  typedef enum logic [2:0] {
    SSRD_IDLE = 3'b001,
    SSRD_SHIFT = 3'b010,
    SSRD_WAIT = 3'b100
  } ssrd_state_t;

  ssrd_state_t state_r;
  logic [7:0] ctrl_r;
  logic [5:0] stat_r;
  logic [7:0] buf_r;
  logic [7:0] txBuf_r;
  logic [7:0] shift_r;
  logic [2:0] bitCnt_r;
  logic shiftFull_r;
  logic outBit_r;
  logic sclkOut_r;
  logic [8:0] divCnt_r;
  logic [2:0] sclkSync_r;
  logic stopPend_r;

  function automatic logic isAddr(input logic [31:0] a, input logic [3:0] ofs);
    return a[31:4] == 28'h0 && a[3:0] == ofs;
  endfunction : isAddr

  logic [1:0] mode;
  logic startBit;
  logic edgeSel;
  logic msbFirst;
  logic [2:0] cks;
  logic extClk;
  logic acc;
  logic wrCtrl;
  logic wrData;
  logic rdData;
  logic rdStat;
  logic forceStop;
  logic sclkNow;
  logic sclkPrev;
  logic launchEdge;
  logic sampleEdge;
  logic halfTick;
  logic byteDone;
  logic shiftIn;
  logic [7:0] nextShift;
  logic [8:0] halfCyc;

  localparam int MODE_LSB = ssrd_pkg::MODE_LSB;
  localparam int START_BIT = ssrd_pkg::START_BIT;
  localparam int EDGE_BIT = ssrd_pkg::EDGE_BIT;
  localparam int ORDER_BIT = ssrd_pkg::ORDER_BIT;
  localparam int CKS_LSB = ssrd_pkg::CKS_LSB;

  assign mode = ctrl_r[MODE_LSB +: 2];
  assign startBit = ctrl_r[START_BIT];
  assign edgeSel = ctrl_r[EDGE_BIT];
  assign msbFirst = ctrl_r[ORDER_BIT];
  assign cks = ctrl_r[CKS_LSB +: 3];
  assign extClk = cks == ssrd_pkg::CKS_EXT;
  assign acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrCtrl = acc && pwrite && isAddr(paddr, ssrd_pkg::CTRL_OFS);
  assign wrData = acc && pwrite && isAddr(paddr, ssrd_pkg::DATA_OFS);
  assign rdData = acc && !pwrite && isAddr(paddr, ssrd_pkg::DATA_OFS);
  assign rdStat = acc && !pwrite && isAddr(paddr, ssrd_pkg::STAT_OFS);
  assign forceStop = wrCtrl && pwdata[1:0] == ssrd_pkg::MODE_OFF && mode != ssrd_pkg::MODE_OFF;

  // Read data; unmapped addresses read zero
  always_comb begin
    prdata = 32'h0;
    if (isAddr(paddr, ssrd_pkg::CTRL_OFS)) begin
      prdata = {24'h0, ctrl_r};
    end else if (isAddr(paddr, ssrd_pkg::STAT_OFS)) begin
      prdata = {26'h0, stat_r};
    end else if (isAddr(paddr, ssrd_pkg::DATA_OFS)) begin
      prdata = {24'h0, buf_r};
    end
  end

  // Serial clock edge detection on the synchronised pin or our own output
  assign sclkNow = extClk ? sclkSync_r[1] : sclkOut_r;
  assign sclkPrev = extClk ? sclkSync_r[2] : ~sclkOut_r;
  assign halfTick = !extClk && state_r == SSRD_SHIFT && divCnt_r == halfCyc - 9'h1;
  // Falling edge launches, rising samples when edge bit is 0
  assign sampleEdge = extClk ? (sclkNow != sclkPrev && sclkNow == !edgeSel)
                             : (halfTick && sclkOut_r == edgeSel);
  assign launchEdge = extClk ? (sclkNow != sclkPrev && sclkNow == edgeSel)
                             : (halfTick && sclkOut_r != edgeSel);
  assign halfCyc = 9'(1 << (cks + 3'(ssrd_pkg::HALF_BASE_LOG2)));
  assign shiftIn = link.peerToPort;
  assign nextShift = msbFirst ? {shift_r[6:0], shiftIn} : {shiftIn, shift_r[7:1]};
  assign byteDone = state_r == SSRD_SHIFT && sampleEdge && bitCnt_r == 3'h7;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclkSync_r <= 3'h7;
    end else begin
      sclkSync_r <= {sclkSync_r[1:0], link.sclk};
    end
  end

  // Control register; edge, order and clock fields locked while in progress
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= ssrd_pkg::CTRL_RST;
    end else if (forceStop) begin
      ctrl_r <= {ctrl_r[7:3], 1'b0, ssrd_pkg::MODE_OFF};
    end else if (wrCtrl && stat_r[ssrd_pkg::ST_INPROG]) begin
      ctrl_r[START_BIT] <= ctrl_r[START_BIT] & pwdata[START_BIT];
    end else if (wrCtrl) begin
      ctrl_r <= pwdata[7:0];
    end else if (state_r == SSRD_IDLE && !stat_r[ssrd_pkg::ST_INPROG]) begin
      ctrl_r <= ctrl_r;
    end
  end

  // Sequencer, shifter and status
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SSRD_IDLE;
      stat_r <= ssrd_pkg::STAT_RST;
      buf_r <= 8'h00;
      txBuf_r <= ssrd_pkg::TXDATA_RST;
      shift_r <= 8'h00;
      bitCnt_r <= 3'h0;
      shiftFull_r <= 1'b0;
      outBit_r <= 1'b1;
      sclkOut_r <= 1'b1;
      divCnt_r <= 9'h0;
      stopPend_r <= 1'b0;
      portInterrupt <= 1'b0;
    end else begin
      portInterrupt <= 1'b0;
      if (rdData) begin
        stat_r[ssrd_pkg::ST_RCOMP] <= 1'b0;
      end
      if (rdStat) begin
        stat_r[ssrd_pkg::ST_OVR] <= 1'b0;
        stat_r[ssrd_pkg::ST_UND] <= 1'b0;
      end
      divCnt_r <= halfTick || state_r != SSRD_SHIFT ? 9'h0 : divCnt_r + 9'h1;
      if (halfTick) begin
        sclkOut_r <= ~sclkOut_r;
      end
      if (wrData && mode == ssrd_pkg::MODE_DUPLEX) begin
        if (stat_r[ssrd_pkg::ST_INPROG] && !shiftFull_r) begin
          shift_r <= pwdata[7:0];
          txBuf_r <= pwdata[7:0];
          shiftFull_r <= 1'b1;
        end else if (stat_r[ssrd_pkg::ST_INPROG]) begin
          txBuf_r <= pwdata[7:0];
          stat_r[ssrd_pkg::ST_TBFULL] <= 1'b1;
        end else begin
          txBuf_r <= pwdata[7:0];
        end
      end
      if (forceStop) begin
        state_r <= SSRD_IDLE;
        stat_r <= ssrd_pkg::STAT_RST;
        sclkOut_r <= 1'b1;
        outBit_r <= 1'b1;
        shiftFull_r <= 1'b0;
        stopPend_r <= 1'b0;
      end else begin
        unique case (state_r)
          SSRD_IDLE: begin
            if (startBit && !stat_r[ssrd_pkg::ST_INPROG] && mode[1]) begin
              state_r <= SSRD_SHIFT;
              stat_r[ssrd_pkg::ST_INPROG] <= 1'b1;
              stat_r[ssrd_pkg::ST_SHIFT] <= 1'b1;
              bitCnt_r <= 3'h0;
              stopPend_r <= 1'b0;
              if (mode == ssrd_pkg::MODE_DUPLEX) begin
                shift_r <= txBuf_r;
                shiftFull_r <= 1'b1;
                outBit_r <= msbFirst ? txBuf_r[7] : txBuf_r[0];
                portInterrupt <= 1'b1;
              end
            end
          end
          SSRD_SHIFT: begin
            if (!startBit && !stopPend_r) begin
              stopPend_r <= 1'b1;
            end
            // Reloaded bytes leave the pin alone until the next launch edge
            if (launchEdge && mode == ssrd_pkg::MODE_DUPLEX) begin
              outBit_r <= msbFirst ? shift_r[7] : shift_r[0];
            end
            if (sampleEdge) begin
              shift_r <= nextShift;
              bitCnt_r <= bitCnt_r + 3'h1;
            end
            if (byteDone) begin
              portInterrupt <= 1'b1;
              if (!stat_r[ssrd_pkg::ST_RCOMP] || rdData) begin
                buf_r <= nextShift;
              end else begin
                stat_r[ssrd_pkg::ST_OVR] <= 1'b1;
              end
              stat_r[ssrd_pkg::ST_RCOMP] <= 1'b1;
              stat_r[ssrd_pkg::ST_SHIFT] <= 1'b0;
              if (stopPend_r || !startBit) begin
                state_r <= SSRD_IDLE;
                stat_r[ssrd_pkg::ST_INPROG] <= 1'b0;
                stat_r[ssrd_pkg::ST_TBFULL] <= 1'b0;
                shiftFull_r <= 1'b0;
                stopPend_r <= 1'b0;
                if (!extClk) begin
                  outBit_r <= 1'b1;
                end
              end else if (mode == ssrd_pkg::MODE_DUPLEX && stat_r[ssrd_pkg::ST_TBFULL]) begin
                shift_r <= txBuf_r;
                stat_r[ssrd_pkg::ST_TBFULL] <= 1'b0;
                stat_r[ssrd_pkg::ST_SHIFT] <= 1'b1;
              end else if (extClk) begin
                stat_r[ssrd_pkg::ST_SHIFT] <= 1'b1;
                if (mode == ssrd_pkg::MODE_DUPLEX) begin
                  shift_r <= txBuf_r;
                  stat_r[ssrd_pkg::ST_UND] <= 1'b1;
                end
              end else begin
                state_r <= SSRD_WAIT;
                shiftFull_r <= 1'b0;
                sclkOut_r <= 1'b1;
                if (mode == ssrd_pkg::MODE_DUPLEX) begin
                  outBit_r <= 1'b1;
                end
              end
            end
          end
          SSRD_WAIT: begin
            // Automatic wait: clock idle until buffer read or next write
            if (!startBit) begin
              state_r <= SSRD_IDLE;
              stat_r[ssrd_pkg::ST_INPROG] <= 1'b0;
              stat_r[ssrd_pkg::ST_SHIFT] <= 1'b0;
              stat_r[ssrd_pkg::ST_TBFULL] <= 1'b0;
              shiftFull_r <= 1'b0;
            end else if ((mode == ssrd_pkg::MODE_RX && rdData) ||
                         (mode == ssrd_pkg::MODE_DUPLEX && wrData)) begin
              state_r <= SSRD_SHIFT;
              stat_r[ssrd_pkg::ST_SHIFT] <= 1'b1;
              bitCnt_r <= 3'h0;
              if (mode == ssrd_pkg::MODE_DUPLEX) begin
                shift_r <= pwdata[7:0];
                shiftFull_r <= 1'b1;
                outBit_r <= msbFirst ? pwdata[7] : pwdata[0];
                portInterrupt <= 1'b1;
              end
            end
          end
          default: state_r <= SSRD_IDLE;
        endcase
      end
    end
  end

  assign link.sclkPortOut = sclkOut_r;
  // Drive the clock only while a mode is active, so a stopped port never fights the peer
  assign link.sclkPortOe = !extClk && mode != ssrd_pkg::MODE_OFF;
  assign link.portToPeer = outBit_r;
endmodule : ssrd_port

//--- test/ssrd_link_chk.sv
// Checker on the serial link between port and peer.
// Assumes external clock mode, edge bit 0, peer half period of four cycles.
`timescale 1ns/1ns
module ssrd_link_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclkPortOut,
  input wire logic sclkPortOe,
  input wire logic sclkPeerOut,
  input wire logic sclkPeerOe,
  input wire logic sclk,
  input wire logic portToPeer,
  input wire logic peerToPort
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic sclkDly_r;
  logic [3:0] idleCnt_r;
  logic [3:0] fallCnt_r;
  sequence lowPhase;
    (!sclk)[*4];
  endsequence
  sequence highPhase;
    sclk[*4];
  endsequence
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) sclkDly_r <= 1'b1;
    else sclkDly_r <= sclk;
  end
  // Long high time marks the gap between frames
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) idleCnt_r <= 4'h0;
    else if (!sclk) idleCnt_r <= 4'h0;
    else if (idleCnt_r != 4'hf) idleCnt_r <= idleCnt_r + 4'h1;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) fallCnt_r <= 4'h0;
    else if (idleCnt_r == 4'hc) fallCnt_r <= 4'h0;
    else if (sclkDly_r && !sclk) fallCnt_r <= fallCnt_r + 4'h1;
  end
  chk_no_fight: assert property (!(sclkPortOe && sclkPeerOe)) else $error("both ends drive sclk");
  chk_peer_drives: assert property (sclkPeerOe) else $error("peer left sclk undriven");
  chk_low_phase: assert property ($fell(sclk) |-> lowPhase ##1 sclk) else $error("bad low phase");
  chk_high_phase: assert property ($rose(sclk) |-> highPhase) else $error("bad high phase");
  chk_tx_steady: assert property ($rose(sclk) |=> $stable(portToPeer)[*3]) else $error("port data moved");
  chk_rx_steady: assert property ($rose(sclk) |=> $stable(peerToPort)[*3]) else $error("peer data moved");
  chk_eight_falls: assert property (fallCnt_r <= 4'h8) else $error("frame too long");
  chk_frame_whole: assert property (idleCnt_r == 4'hb |-> fallCnt_r == 4'h0 || fallCnt_r == 4'h8)
    else $error("partial frame");
endmodule : ssrd_link_chk

//--- test/sync_serial_receive_duplex_tb_top.sv
// Bench: port and peer joined by the link; APB and peer requests driven here.
// Assumes external clock only, since the peer always drives the link clock.
`timescale 1ns/1ns
module sync_serial_receive_duplex_tb_top;
  localparam logic [31:0] CTRL = 32'(ssrd_pkg::CTRL_OFS);
  localparam logic [31:0] STAT = 32'(ssrd_pkg::STAT_OFS);
  localparam logic [31:0] DATA = 32'(ssrd_pkg::DATA_OFS);
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic portInterrupt;
  logic go = 1'b0;
  logic [7:0] replyByte = 8'h00;
  logic peerBusy;
  logic [7:0] peerRx;
  logic peerValid;
  logic [7:0] lastRx = 8'h00;
  logic [31:0] rd;
  int irqCount = 0;
  int irqBase = 0;
  int badCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  ssrd_link_if ssrd_link_if_inst ();
  ssrd_port ssrd_port_inst (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .portInterrupt(portInterrupt), .link(ssrd_link_if_inst.port));
  ssrd_peer ssrd_peer_inst (.clock(clock), .rst_b(rst_b), .go(go), .replyByte(replyByte), .busy(peerBusy),
    .rxByte(peerRx), .rxValid(peerValid), .link(ssrd_link_if_inst.peer));
  ssrd_link_chk ssrd_link_chk_inst (.clock(clock), .rst_b(rst_b),
    .sclkPortOut(ssrd_link_if_inst.sclkPortOut), .sclkPortOe(ssrd_link_if_inst.sclkPortOe),
    .sclkPeerOut(ssrd_link_if_inst.sclkPeerOut), .sclkPeerOe(ssrd_link_if_inst.sclkPeerOe),
    .sclk(ssrd_link_if_inst.sclk), .portToPeer(ssrd_link_if_inst.portToPeer),
    .peerToPort(ssrd_link_if_inst.peerToPort));
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (portInterrupt === 1'b1) irqCount <= irqCount + 1;
    if (peerValid === 1'b1) lastRx <= peerRx;
    if (cycles == 8000) begin
      badCount++;
      close_out();
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Called right after an edge; one edge passes after release
  task apbXfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apbXfer
  task rdChk(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apbXfer(1'b0, a, 32'h0);
    check(rd & mask, exp);
  endtask : rdChk
  task irqChk(input int n);
    check(32'(irqCount - irqBase), 32'(n));
    irqBase = irqCount;
  endtask : irqChk
  task peerStart(input logic [7:0] b);
    go <= 1'b1;
    replyByte <= b;
    @(posedge clock);
    go <= 1'b0;
  endtask : peerStart
  // Extra idle keeps frames apart for the link checker
  task peerWait;
    int n;
    n = 0;
    repeat (2) @(posedge clock);
    while (peerBusy !== 1'b0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    repeat (16) @(posedge clock);
  endtask : peerWait
  task peerXfer(input logic [7:0] b);
    peerStart(b);
    peerWait();
  endtask : peerXfer
  // Control words: external clock, MSB first, edge bit 0
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rdChk(CTRL, 32'hffffffff, 32'h0);
    rdChk(STAT, 32'hffffffff, 32'h0);
    rdChk(32'hc, 32'hffffffff, 32'h0);
    check(32'(ssrd_link_if_inst.portToPeer), 32'h1);
    $display("test reset done");
    apbXfer(1'b1, CTRL, 32'hf6);
    rdChk(STAT, 32'h3f, 32'h03);
    apbXfer(1'b1, CTRL, 32'h16);
    rdChk(CTRL, 32'hff, 32'hf6);
    irqBase = irqCount;
    peerXfer(8'ha5);
    irqChk(1);
    rdChk(STAT, 32'h3d, 32'h05);
    peerXfer(8'h3c);
    rdChk(STAT, 32'h3d, 32'h0d);
    rdChk(STAT, 32'h3d, 32'h05);
    rdChk(DATA, 32'hff, 32'ha5);
    rdChk(STAT, 32'h3d, 32'h01);
    irqBase = irqCount;
    peerStart(8'h69);
    repeat (12) @(posedge clock);
    apbXfer(1'b1, CTRL, 32'hf2);
    peerWait();
    irqChk(1);
    rdChk(STAT, 32'h3f, 32'h04);
    rdChk(DATA, 32'hff, 32'h69);
    apbXfer(1'b1, CTRL, 32'hf6);
    peerXfer(8'h0f);
    apbXfer(1'b1, CTRL, 32'h0);
    rdChk(STAT, 32'h3f, 32'h0);
    rdChk(CTRL, 32'hff, 32'hf0);
    $display("test receive done");
    apbXfer(1'b1, CTRL, 32'hf3);
    apbXfer(1'b1, DATA, 32'h5a);
    irqBase = irqCount;
    apbXfer(1'b1, CTRL, 32'hf7);
    rdChk(STAT, 32'h3f, 32'h03);
    apbXfer(1'b1, DATA, 32'hc3);
    rdChk(STAT, 32'h20, 32'h20);
    peerXfer(8'h96);
    check(32'(lastRx), 32'h5a);
    rdChk(STAT, 32'h3d, 32'h05);
    rdChk(DATA, 32'hff, 32'h96);
    peerXfer(8'h11);
    check(32'(lastRx), 32'hc3);
    peerXfer(8'h22);
    check(32'(lastRx), 32'hc3);
    rdChk(STAT, 32'h1c, 32'h1c);
    rdChk(STAT, 32'h18, 32'h0);
    irqChk(4);
    apbXfer(1'b1, CTRL, 32'h0);
    rdChk(STAT, 32'h3f, 32'h0);
    check(32'(ssrd_link_if_inst.portToPeer), 32'h1);
    apbXfer(1'b1, CTRL, 32'hf3);
    apbXfer(1'b1, DATA, 32'h80);
    irqBase = irqCount;
    apbXfer(1'b1, CTRL, 32'hf7);
    apbXfer(1'b1, CTRL, 32'hf3);
    rdChk(STAT, 32'h03, 32'h03);
    peerXfer(8'h44);
    check(32'(lastRx), 32'h80);
    irqChk(2);
    rdChk(STAT, 32'h3f, 32'h04);
    check(32'(ssrd_link_if_inst.portToPeer), 32'h0);
    apbXfer(1'b1, CTRL, 32'h0);
    check(32'(ssrd_link_if_inst.portToPeer), 32'h1);
    $display("test duplex done");
    close_out();
  end
endmodule : sync_serial_receive_duplex_tb_top
